// File: csdb_top.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module csdb_top #(
  parameter int unsigned TIMER_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Shutdown sources
  input wire logic [TIMER_W-1:0] limit_timer1_count_i,
  input wire logic [TIMER_W-1:0] limit_timer1_period_i,
  input wire logic [TIMER_W-1:0] limit_timer2_count_i,
  input wire logic [TIMER_W-1:0] limit_timer2_period_i,
  input wire logic comparator1_i,
  input wire logic comparator2_i,
  input wire logic fault_input_pin_i,
  // Waveform
  input wire logic wave_i,
  input wire logic [1:0] inactive_level_i,
  output logic primary_drive_output_o,
  output logic primary_drive_output_oe_o,
  output logic complementary_drive_output_o,
  output logic complementary_drive_output_oe_o,
  output logic shutdown_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [csdb_pkg::SRC_W-1:0] shutdown_source_enables_q;
  logic [csdb_pkg::DB_W-1:0] rising_deadband_value_q;
  logic [csdb_pkg::DB_W-1:0] falling_deadband_value_q;
  logic [1:0] time_source_q;
  logic [3:0] override_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;

  always_comb begin
    rdata_d = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_i)
      csdb_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES: rdata_d[4:0] = shutdown_source_enables_q;
      csdb_pkg::ADDR_RISING_DEADBAND_COUNT: rdata_d[3:0] = rising_deadband_value_q;
      csdb_pkg::ADDR_FALLING_DEADBAND_COUNT: rdata_d[3:0] = falling_deadband_value_q;
      csdb_pkg::ADDR_DEADBAND_CONTROL: rdata_d[1:0] = time_source_q;
      csdb_pkg::ADDR_SHUTDOWN_CONTROL: rdata_d[3:0] = override_q;
      csdb_pkg::ADDR_STATUS: rdata_d[2:0] = {complementary_drive_output_o,
                                             primary_drive_output_o, shutdown_o};
      default: addr_ok = 1'b0;
    endcase
  end

  // Error only in the access phase so the answer is a defined pulse
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign prdata_o = prdata_q;

  // Read data captured combinationally would glitch; registered copy tracks address
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= rdata_d;
    end else if (rd_en) begin
      prdata_q <= prdata_q;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shutdown_source_enables_q <= csdb_pkg::SRC_RESET;
    end else if (wr_en && paddr_i == csdb_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES) begin
      shutdown_source_enables_q <= pwdata_i[csdb_pkg::SRC_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rising_deadband_value_q <= csdb_pkg::DB_RESET;
      falling_deadband_value_q <= csdb_pkg::DB_RESET;
    end else if (wr_en) begin
      if (paddr_i == csdb_pkg::ADDR_RISING_DEADBAND_COUNT) begin
        rising_deadband_value_q <= pwdata_i[csdb_pkg::DB_W-1:0];
      end
      if (paddr_i == csdb_pkg::ADDR_FALLING_DEADBAND_COUNT) begin
        falling_deadband_value_q <= pwdata_i[csdb_pkg::DB_W-1:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      time_source_q <= csdb_pkg::TS_RESET;
      override_q <= csdb_pkg::OVR_RESET;
    end else if (wr_en) begin
      if (paddr_i == csdb_pkg::ADDR_DEADBAND_CONTROL) begin
        time_source_q <= pwdata_i[1:0];
      end
      if (paddr_i == csdb_pkg::ADDR_SHUTDOWN_CONTROL) begin
        override_q <= pwdata_i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_q <= 3'h7;
      pin_sync_q <= 3'h7;
    end else begin
      pin_meta_q <= {fault_input_pin_i, comparator2_i, comparator1_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Shutdown
  // ----------------------------------------------------------------
  logic [csdb_pkg::SRC_W-1:0] cond;
  logic shutdown_q;

  always_comb begin
    cond = '0;
    cond[csdb_pkg::LT2_BIT] = (limit_timer2_count_i == limit_timer2_period_i);
    cond[csdb_pkg::LT1_BIT] = (limit_timer1_count_i == limit_timer1_period_i);
    cond[csdb_pkg::COMP2_BIT] = !pin_sync_q[1];
    cond[csdb_pkg::COMP1_BIT] = !pin_sync_q[0];
    cond[csdb_pkg::FAULT_PIN_BIT] = !pin_sync_q[2];
  end

  // Level follows the sources; latching and restart are out of scope
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shutdown_q <= 1'b0;
    end else begin
      shutdown_q <= |(cond & shutdown_source_enables_q);
    end
  end

  assign shutdown_o = shutdown_q;

  // ----------------------------------------------------------------
  // Dead band
  // ----------------------------------------------------------------
  logic [1:0] chain_cnt_q;
  logic chain_tick;
  logic rise_tick;
  logic fall_tick;
  logic primary_raw;
  logic compl_raw;

  // Delay chain modelled as a clocked element; no analog chain exists here
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chain_cnt_q <= 2'h0;
    end else if (chain_cnt_q == 2'(csdb_pkg::CHAIN_ELEM_CYCLES - 1)) begin
      chain_cnt_q <= 2'h0;
    end else begin
      chain_cnt_q <= chain_cnt_q + 2'h1;
    end
  end

  assign chain_tick = (chain_cnt_q == 2'(csdb_pkg::CHAIN_ELEM_CYCLES - 1));
  assign rise_tick = time_source_q[csdb_pkg::RISE_TS_BIT] ? chain_tick : 1'b1;
  assign fall_tick = time_source_q[csdb_pkg::FALL_TS_BIT] ? chain_tick : 1'b1;

  csdb_delay u_rise (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .tick_i(rise_tick),
    .count_i(rising_deadband_value_q),
    .in_i(wave_i),
    .out_o(primary_raw)
  );

  csdb_delay u_fall (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .tick_i(fall_tick),
    .count_i(falling_deadband_value_q),
    .in_i(!wave_i),
    .out_o(compl_raw)
  );

  // ----------------------------------------------------------------
  // Outputs with override
  // ----------------------------------------------------------------
  function automatic csdb_pkg::csdb_pin_s drive(input logic raw, input logic sd,
                                                 input logic [1:0] sel, input logic inact);
    csdb_pkg::csdb_pin_s p;
    p.oe = 1'b1;
    p.level = raw;
    if (sd) begin
      case (sel)
        csdb_pkg::OVR_LOW: p.level = 1'b0;
        csdb_pkg::OVR_HIGH: p.level = 1'b1;
        csdb_pkg::OVR_INACTIVE: p.level = inact;
        default: begin
          p.level = 1'b0;
          p.oe = 1'b0;
        end
      endcase
    end
    return p;
  endfunction

  csdb_pkg::csdb_pin_s pin0_q;
  csdb_pkg::csdb_pin_s pin1_q;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin0_q <= '0;
      pin1_q <= '0;
    end else begin
      pin0_q <= drive(primary_raw, shutdown_q, override_q[csdb_pkg::OVR0_LSB +: 2],
                      inactive_level_i[0]);
      pin1_q <= drive(compl_raw, shutdown_q, override_q[csdb_pkg::OVR1_LSB +: 2],
                      inactive_level_i[1]);
    end
  end

  assign primary_drive_output_o = pin0_q.level;
  assign primary_drive_output_oe_o = pin0_q.oe;
  assign complementary_drive_output_o = pin1_q.level;
  assign complementary_drive_output_oe_o = pin1_q.oe;

endmodule

`default_nettype wire

// File: csdb_pkg.sv
package csdb_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SHUTDOWN_SOURCE_ENABLES = 8'h00;
  localparam logic [7:0] ADDR_RISING_DEADBAND_COUNT = 8'h04;
  localparam logic [7:0] ADDR_FALLING_DEADBAND_COUNT = 8'h08;
  localparam logic [7:0] ADDR_DEADBAND_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_SHUTDOWN_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FAULT_PIN_BIT = 0;
  localparam int unsigned COMP1_BIT = 1;
  localparam int unsigned COMP2_BIT = 2;
  localparam int unsigned LT1_BIT = 3;
  localparam int unsigned LT2_BIT = 4;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned DB_W = 4;
  localparam int unsigned RISE_TS_BIT = 0;
  localparam int unsigned FALL_TS_BIT = 1;
  localparam int unsigned OVR0_LSB = 0;
  localparam int unsigned OVR1_LSB = 2;
  localparam int unsigned ST_SHUTDOWN_BIT = 0;
  localparam int unsigned ST_PRIMARY_BIT = 1;
  localparam int unsigned ST_COMPL_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_RESET = 5'h00;
  localparam logic [DB_W-1:0] DB_RESET = 4'h0;
  localparam logic [1:0] TS_RESET = 2'h0;
  localparam logic [3:0] OVR_RESET = 4'h0;

  // Override level selections
  localparam logic [1:0] OVR_LOW = 2'h0;
  localparam logic [1:0] OVR_HIGH = 2'h1;
  localparam logic [1:0] OVR_INACTIVE = 2'h2;
  localparam logic [1:0] OVR_TRISTATE = 2'h3;

  // Delay chain element, in generator clocks
  localparam int unsigned CHAIN_ELEM_CYCLES = 1;

  typedef enum logic [2:0] {
    CSDB_IDLE = 3'b001,
    CSDB_WAIT = 3'b010,
    CSDB_ON = 3'b100
  } csdb_edge_e;

  typedef struct packed {
    logic oe;
    logic level;
  } csdb_pin_s;

endpackage

// File: csdb_delay.sv
`timescale 1ns/1ps
`default_nettype none

// Delays the rising edge of an input by a count of ticks; falls at once.
module csdb_delay (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Timing
  input wire logic tick_i,
  input wire logic [csdb_pkg::DB_W-1:0] count_i,
  // Signal
  input wire logic in_i,
  output logic out_o
);

  csdb_pkg::csdb_edge_e state_q;
  logic [csdb_pkg::DB_W-1:0] left_q;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= csdb_pkg::CSDB_IDLE;
      left_q <= csdb_pkg::DB_RESET;
    end else begin
      case (state_q)
        csdb_pkg::CSDB_IDLE: begin
          if (in_i) begin
            left_q <= count_i;
            state_q <= (count_i == '0) ? csdb_pkg::CSDB_ON : csdb_pkg::CSDB_WAIT;
          end
        end
        csdb_pkg::CSDB_WAIT: begin
          if (!in_i) begin
            state_q <= csdb_pkg::CSDB_IDLE;
          end else if (tick_i) begin
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
              state_q <= csdb_pkg::CSDB_ON;
            end
          end
        end
        csdb_pkg::CSDB_ON: begin
          if (!in_i) begin
            state_q <= csdb_pkg::CSDB_IDLE;
          end
        end
        default: begin
          state_q <= csdb_pkg::CSDB_IDLE;
        end
      endcase
    end
  end

  assign out_o = (state_q == csdb_pkg::CSDB_ON) && in_i;

endmodule

`default_nettype wire

// File: csdb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module csdb_monitor #(
  parameter int unsigned TIMER_W = 8
) (
  // Clock, reset, bus
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  // Sources and outputs
  input wire logic [TIMER_W-1:0] limit_timer1_count_i,
  input wire logic [TIMER_W-1:0] limit_timer1_period_i,
  input wire logic [TIMER_W-1:0] limit_timer2_count_i,
  input wire logic [TIMER_W-1:0] limit_timer2_period_i,
  input wire logic comparator1_i,
  input wire logic comparator2_i,
  input wire logic fault_input_pin_i,
  input wire logic primary_drive_output_oe_o,
  input wire logic shutdown_o
);
  logic [4:0] en_q;
  logic [1:0] ovr_q;
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i;
  // Shadow copies, so the checker needs no peek inside
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) en_q <= 5'h00;
    else if (wr && paddr_i == csdb_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES) en_q <= pwdata_i[4:0];
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) ovr_q <= 2'h0;
    else if (wr && paddr_i == csdb_pkg::ADDR_SHUTDOWN_CONTROL) ovr_q <= pwdata_i[1:0];
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Pins pass two sync stages first
  sequence s_held(c);
    c[*3];
  endsequence
  AST_LT2: assert property (
    en_q[4] && limit_timer2_count_i == limit_timer2_period_i |=> shutdown_o)
    else $error("lt2 match missed");
  AST_LT1: assert property (
    en_q[3] && limit_timer1_count_i == limit_timer1_period_i |=> shutdown_o)
    else $error("lt1 match missed");
  AST_CMP2: assert property (
    s_held(en_q[2] && !comparator2_i) |=> shutdown_o)
    else $error("cmp2 low missed");
  AST_CMP1: assert property (
    s_held(en_q[1] && !comparator1_i) |=> shutdown_o)
    else $error("cmp1 low missed");
  AST_FLT: assert property (
    s_held(en_q[0] && !fault_input_pin_i) |=> shutdown_o)
    else $error("fault low missed");
  AST_QUIET: assert property (
    (en_q == 5'h00)[*4] |=> !shutdown_o)
    else $error("shutdown with no source");
  AST_RDB: assert property (
    psel_i && penable_i && !pwrite_i && (paddr_i == csdb_pkg::ADDR_RISING_DEADBAND_COUNT
    || paddr_i == csdb_pkg::ADDR_FALLING_DEADBAND_COUNT) |-> prdata_o[31:4] == 28'h0)
    else $error("dead band upper bits set");
  AST_TRI: assert property (
    (shutdown_o && ovr_q == 2'h3)[*2] |-> !primary_drive_output_oe_o)
    else $error("primary driven in float mode");
endmodule
`default_nettype wire

// File: csdb_gate_model.sv
`timescale 1ns/1ps
`default_nettype none
module csdb_gate_model (
  // Trip requests: bit0 fault, bit1 cmp1, bit2 cmp2
  input wire logic [2:0] trip_i,
  // Source levels, idle high
  output logic fault_o,
  output logic comparator1_o,
  output logic comparator2_o,
  // Gate pin
  input wire logic level_i,
  input wire logic oe_i,
  output logic pin_o
);
  assign fault_o = !trip_i[0];
  assign comparator1_o = !trip_i[1];
  assign comparator2_o = !trip_i[2];
  // Gate input pulled down: a released pin must read low, never hold
  assign pin_o = oe_i ? level_i : 1'b0;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i, nrst_i, psel, penable, pwrite, wave, pready, pslverr, err;
  logic prim, prim_oe, comp, comp_oe, shut, c1, c2, flt, pin;
  logic [7:0] paddr, t1c, t1p, t2c, t2p;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] trip;
  int fails, compares, n, ts, j, cnt;
  int nv[3] = '{0, 5, 15};
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  csdb_top #(.TIMER_W(8)) dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .limit_timer1_count_i(t1c), .limit_timer1_period_i(t1p),
    .limit_timer2_count_i(t2c), .limit_timer2_period_i(t2p),
    .comparator1_i(c1), .comparator2_i(c2), .fault_input_pin_i(flt),
    .wave_i(wave), .inactive_level_i(2'h2), .primary_drive_output_o(prim),
    .primary_drive_output_oe_o(prim_oe), .complementary_drive_output_o(comp),
    .complementary_drive_output_oe_o(comp_oe), .shutdown_o(shut));
  csdb_gate_model model_u (.trip_i(trip), .fault_o(flt), .comparator1_o(c1),
    .comparator2_o(c2), .level_i(prim), .oe_i(prim_oe), .pin_o(pin));
  // ----
  // Tasks
  // ----
  task test_done;
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    if (k >= 20) begin
      fails++;
      test_done;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cond(input int i, input logic on);
    @(posedge clock_i);
    if (i < 3) trip[i] <= on;
    else if (i == 3) t1c <= on ? t1p : 8'h00;
    else t2c <= on ? t2p : 8'h00;
  endtask
  task sd_chk(input logic exp);
    repeat (5) @(negedge clock_i);
    chk({31'h0, shut}, {31'h0, exp});
  endtask
  task meas(input logic rise);
    @(posedge clock_i);
    wave <= rise;
    cnt = 0;
    do begin
      @(negedge clock_i);
      cnt++;
    end while ((rise ? prim : comp) !== 1'b1 && cnt < 60);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    nrst_i = 1'b0;
    {psel, penable, pwrite, wave, err, paddr, pwdata, q, trip, t1c, t2c} = '0;
    t1p = 8'h5a;
    t2p = 8'ha5;
    fails = 0;
    compares = 0;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (n = 0; n < 3; n++) begin
      apb(1'b0, 8'(n * 4), 32'h0);
      chk(q, 32'h0);
      apb(1'b1, 8'(n * 4), 32'hffffffff);
      apb(1'b0, 8'(n * 4), 32'h0);
      chk(q, n == 0 ? 32'h1f : 32'h0f);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({err, q[30:0]}, 32'h80000000);
    for (n = 0; n < 5; n++) begin
      apb(1'b1, csdb_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES, 32'h1f ^ (32'h1 << n));
      cond(n, 1'b1);
      sd_chk(1'b0);
      apb(1'b1, csdb_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES, 32'h1 << n);
      sd_chk(1'b1);
      apb(1'b1, csdb_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES, 32'h1f);
      sd_chk(1'b1);
      cond(n, 1'b0);
      sd_chk(1'b0);
    end
    cond(0, 1'b1);
    apb(1'b1, csdb_pkg::ADDR_SHUTDOWN_CONTROL, 32'hf);
    sd_chk(1'b1);
    chk({29'h0, comp_oe, prim_oe, pin}, 32'h0);
    apb(1'b1, csdb_pkg::ADDR_SHUTDOWN_CONTROL, 32'h9);
    sd_chk(1'b1);
    // Complementary takes its inactive level, which is tied high here
    chk({28'h0, comp_oe, comp, prim_oe, pin}, 32'hf);
    apb(1'b0, csdb_pkg::ADDR_SHUTDOWN_CONTROL, 32'h0);
    chk(q, 32'h9);
    apb(1'b0, csdb_pkg::ADDR_STATUS, 32'h0);
    chk(q, 32'h7);
    cond(0, 1'b0);
    apb(1'b1, csdb_pkg::ADDR_SHUTDOWN_SOURCE_ENABLES, 32'h0);
    // Both counts share one value so each edge sees the same delay
    for (ts = 0; ts < 2; ts++) begin
      for (j = 0; j < 3; j++) begin
        apb(1'b1, csdb_pkg::ADDR_DEADBAND_CONTROL, ts == 1 ? 32'h3 : 32'h0);
        apb(1'b0, csdb_pkg::ADDR_DEADBAND_CONTROL, 32'h0);
        chk(q, ts == 1 ? 32'h3 : 32'h0);
        apb(1'b1, csdb_pkg::ADDR_RISING_DEADBAND_COUNT, 32'(nv[j]));
        apb(1'b1, csdb_pkg::ADDR_FALLING_DEADBAND_COUNT, 32'(nv[j]));
        meas(1'b1);
        chk(32'(cnt), 32'(nv[j] * (ts == 1 ? csdb_pkg::CHAIN_ELEM_CYCLES : 1) + 3));
        meas(1'b0);
        chk(32'(cnt), 32'(nv[j] * (ts == 1 ? csdb_pkg::CHAIN_ELEM_CYCLES : 1) + 3));
      end
    end
    test_done;
  end
endmodule
bind csdb_top csdb_monitor #(.TIMER_W(TIMER_W)) mon_u (.clock_i(clock_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .limit_timer1_count_i(limit_timer1_count_i),
  .limit_timer1_period_i(limit_timer1_period_i), .limit_timer2_count_i(limit_timer2_count_i),
  .limit_timer2_period_i(limit_timer2_period_i), .comparator1_i(comparator1_i),
  .comparator2_i(comparator2_i), .fault_input_pin_i(fault_input_pin_i),
  .primary_drive_output_oe_o(primary_drive_output_oe_o), .shutdown_o(shutdown_o));
`default_nettype wire
